/* src/gspr_pad_drive.sv */
// gspr_pad_drive: turns a level and a drive style into pad controls
// assumes the pad has a weak keeper driven by pad_weak
`timescale 1ns/1ns
module gspr_pad_drive (
	input  wire logic [2:0] drive,
	input  wire logic       level,
	input  wire logic       active,
	output logic            pad_out,
	output logic            pad_oe,
	output logic            pad_weak
);
	import gspr_pkg::*;
	always_comb begin
		pad_out  = level;
		pad_oe   = 1'b0;
		pad_weak = 1'b0;
		if (active) begin
			unique case (gspr_drv_e'(drive))
				GSPR_DRV_PUSHPULL:   pad_oe = 1'b1;
				GSPR_DRV_LOW_WEAKH: begin
					pad_oe   = ~level;
					pad_weak = level;
				end
				GSPR_DRV_LOW_HIZ:    pad_oe = ~level;
				GSPR_DRV_WEAKL_HIGH: begin
					pad_oe   = level;
					pad_weak = ~level;
				end
				GSPR_DRV_HIZ_HIGH:   pad_oe = level;
				default:             pad_oe = 1'b0;
			endcase
		end
	end
endmodule

/* src/gspr_pkg.sv */
// gspr_pkg: constants for the gpio and serial pin routing block
// assumes an 8-bit register port with byte addresses as printed
package gspr_pkg;
	localparam logic [7:0] GSPR_ADDR_VALUE   = 8'h0e;
	localparam logic [7:0] GSPR_ADDR_ROUTING = 8'h0f;
	localparam logic [7:0] GSPR_ADDR_DOUTCFG = 8'h10;
	localparam logic [7:0] GSPR_RST_VALUE    = 8'h00;
	localparam logic [7:0] GSPR_RST_ROUTING  = 8'h00;
	localparam logic [7:0] GSPR_RST_DOUTCFG  = 8'h52;
	// writable bit masks; other bits are read-only
	localparam logic [7:0] GSPR_WMASK_VALUE   = 8'he0;
	localparam logic [7:0] GSPR_WMASK_ROUTING = 8'h7f;
	localparam logic [7:0] GSPR_WMASK_DOUTCFG = 8'hff;
	localparam int GSPR_BIT_BIDIR_VAL   = 7;
	localparam int GSPR_BIT_OUTONLY_VAL = 5;
	localparam int GSPR_BIT_BIDIR_MON   = 3;
	localparam int GSPR_BIT_IN2_MON     = 2;
	localparam int GSPR_BIT_IN1_MON     = 1;
	localparam int GSPR_BIT_DATA_OUT_PIN_VALUE    = 3;
	localparam int GSPR_BIT_BCLK_SEL    = 1;
	localparam int GSPR_BIT_FSYNC_SEL   = 0;
	localparam logic [1:0] GSPR_SRC_NONE  = 2'h0;
	localparam logic [1:0] GSPR_SRC_BIDIR = 2'h1;
	localparam logic [1:0] GSPR_SRC_IN2   = 2'h2;
	localparam logic [1:0] GSPR_SRC_IN1   = 2'h3;
	localparam logic [2:0] GSPR_DIN2_DOUT = 3'h4;
	localparam logic [2:0] GSPR_DIN2_DIN  = 3'h5;
	localparam logic [3:0] GSPR_FN_GPO = 4'h2;
	typedef enum logic [3:0] {
		GSPR_FN_DISABLED = 4'h0, GSPR_FN_INPUT = 4'h1,
		GSPR_FN_GENOUT = 4'h2, GSPR_FN_IRQ = 4'h3, GSPR_FN_PULSE_DENSITY_CLOCK_OUT = 4'h4,
		GSPR_FN_PDOUT = 4'h5, GSPR_FN_PDOUT2 = 4'h6, GSPR_FN_SDOUT = 4'h7,
		GSPR_FN_SDOUT2 = 4'h8, GSPR_FN_SBCLK = 4'h9, GSPR_FN_GENERAL_CLOCK_OUTPUT = 4'ha,
		GSPR_FN_UNDEF = 4'hb, GSPR_FN_MUXED = 4'hc, GSPR_FN_DAISY = 4'hd,
		GSPR_FN_LOOP = 4'he, GSPR_FN_RSVD = 4'hf
	} gspr_fn_e;
	typedef enum logic [2:0] {
		GSPR_DRV_HIZ = 3'h0, GSPR_DRV_PUSHPULL = 3'h1, GSPR_DRV_LOW_WEAKH = 3'h2,
		GSPR_DRV_LOW_HIZ = 3'h3, GSPR_DRV_WEAKL_HIGH = 3'h4,
		GSPR_DRV_HIZ_HIGH = 3'h5, GSPR_DRV_RSVD6 = 3'h6, GSPR_DRV_RSVD7 = 3'h7
	} gspr_drv_e;
endpackage

/* src/gspr_src_sel.sv */
// gspr_src_sel: picks one pin level by a small source code
// assumes code 0 means no source and yields a low level
`timescale 1ns/1ns
module gspr_src_sel (
	input  wire logic [2:0] code,
	input  wire logic       bidir_level,
	input  wire logic       in_two_level,
	input  wire logic       in_one_level,
	input  wire logic       dout_level,
	input  wire logic       din_level,
	output logic            level,
	output logic            enabled
);
	import gspr_pkg::*;
	always_comb begin
		level   = 1'b0;
		enabled = 1'b1;
		unique case (code)
			3'h1: level = bidir_level;
			3'h2: level = in_two_level;
			3'h3: level = in_one_level;
			GSPR_DIN2_DOUT: level = dout_level;
			GSPR_DIN2_DIN: level = din_level;
			default: enabled = 1'b0;
		endcase
	end
endmodule

/* src/gspr_top.sv */
// gspr_top: register file and pin routing for the general pins
// assumes a simple synchronous 8-bit register port and synchronous pins
`timescale 1ns/1ns
module gspr_top (
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	input  wire logic [3:0] outonly_pin_function,
	input  wire logic       bidir_is_output,
	input  wire logic       bidir_is_input,
	input  wire logic       input_pin_one_enabled,
	input  wire logic       input_pin_two_enabled,
	input  wire logic       bidir_pin_in,
	output logic            bidir_pin_out,
	output logic            bidir_pin_oe,
	output logic            outonly_pin_gpo_out,
	output logic            outonly_pin_gpo_active,
	input  wire logic       input_pin_one,
	input  wire logic       input_pin_two,
	input  wire logic       primary_din_pin,
	input  wire logic       primary_bclk_pin,
	input  wire logic       primary_fsync_pin,
	input  wire logic       secondary_bclk,
	input  wire logic       secondary_fsync,
	output logic            control_clock,
	output logic            control_clock_active,
	output logic            primary_second_input,
	output logic            primary_second_input_en,
	output logic            primary_bclk,
	output logic            primary_fsync,
	input  wire logic [7:0] data_out_sources,
	output logic      [3:0] data_out_function,
	output logic            data_out_pin_out,
	output logic            data_out_pin_oe,
	output logic            data_out_pin_weak,
	input  wire logic       data_out_pin_in,
	output logic            data_out_input_level
);
	import gspr_pkg::*;

	typedef struct packed {
		logic [7:0] value;
		logic [7:0] routing;
		logic [7:0] doutcfg;
		logic [2:0] mon;
		logic [7:0] rdata;
	} gspr_state_s;

	gspr_state_s st;
	gspr_state_s next_st;
	logic [1:0]  cclk_code;
	logic [2:0]  din2_code;
	logic        dout_level;
	logic        dout_active;
	logic        din2_level;
	logic        din2_en;
	gspr_fn_e    fn;

	assign cclk_code = st.routing[6:5];
	assign din2_code = st.routing[4:2];
	assign fn        = gspr_fn_e'(st.doutcfg[7:4]);

	always_comb begin
		next_st = st;
		// write masks keep reserved bits at reset value
		if (reg_wr) begin
			unique case (reg_addr)
				GSPR_ADDR_VALUE: next_st.value =
					(st.value & ~GSPR_WMASK_VALUE) |
					(reg_wdata & GSPR_WMASK_VALUE);
				GSPR_ADDR_ROUTING: next_st.routing =
					reg_wdata & GSPR_WMASK_ROUTING;
				GSPR_ADDR_DOUTCFG: next_st.doutcfg = reg_wdata;
				default: next_st.value = st.value;
			endcase
		end
		// monitors follow pins only while set up as inputs
		if (bidir_is_input)
			next_st.mon[2] = bidir_pin_in;
		if (input_pin_two_enabled)
			next_st.mon[1] = input_pin_two;
		if (input_pin_one_enabled)
			next_st.mon[0] = input_pin_one;
		// bit 6 is writable storage; only monitors are live on read
		unique case (reg_addr)
			GSPR_ADDR_VALUE: next_st.rdata = {st.value[7:5], 1'b0,
				st.mon, 1'b0};
			GSPR_ADDR_ROUTING: next_st.rdata = st.routing;
			GSPR_ADDR_DOUTCFG: next_st.rdata = st.doutcfg;
			default: next_st.rdata = 8'h00;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st.value   <= GSPR_RST_VALUE;
			st.routing <= GSPR_RST_ROUTING;
			st.doutcfg <= GSPR_RST_DOUTCFG;
			st.mon     <= 3'h0;
			st.rdata   <= 8'h00;
		end else begin
			st <= next_st;
		end
	end

	assign reg_rdata = st.rdata;

	// value bits stay stored whatever the pin does
	assign bidir_pin_out = st.value[GSPR_BIT_BIDIR_VAL];
	assign bidir_pin_oe  = bidir_is_output;
	assign outonly_pin_gpo_out =
		st.value[GSPR_BIT_OUTONLY_VAL];
	assign outonly_pin_gpo_active =
		(outonly_pin_function == GSPR_FN_GPO);

	always_comb begin
		control_clock        = 1'b0;
		control_clock_active = 1'b1;
		unique case (cclk_code)
			GSPR_SRC_NONE:  control_clock_active = 1'b0;
			GSPR_SRC_BIDIR: control_clock = bidir_pin_in;
			GSPR_SRC_IN2:   control_clock = input_pin_two;
			GSPR_SRC_IN1:   control_clock = input_pin_one;
		endcase
	end

	gspr_src_sel u_din2 (
		.code         (din2_code),
		.bidir_level  (bidir_pin_in),
		.in_two_level (input_pin_two),
		.in_one_level (input_pin_one),
		.dout_level   (data_out_pin_in),
		.din_level    (primary_din_pin),
		.level        (din2_level),
		.enabled      (din2_en)
	);
	assign primary_second_input    = din2_level;
	assign primary_second_input_en = din2_en;

	assign primary_bclk = st.routing[GSPR_BIT_BCLK_SEL] ?
		secondary_bclk : primary_bclk_pin;
	assign primary_fsync = st.routing[GSPR_BIT_FSYNC_SEL] ?
		secondary_fsync : primary_fsync_pin;

	// data_out_sources: [0] irq [1] pdm clk [2] primary out [3] primary out2
	// [4] secondary out [5] secondary out2 [6] secondary bclk [7] clock out
	always_comb begin
		dout_level  = 1'b0;
		dout_active = 1'b1;
		unique case (fn)
			GSPR_FN_GENOUT: dout_level =
				st.doutcfg[GSPR_BIT_DATA_OUT_PIN_VALUE];
			GSPR_FN_IRQ:    dout_level = data_out_sources[0];
			GSPR_FN_PULSE_DENSITY_CLOCK_OUT: dout_level = data_out_sources[1];
			GSPR_FN_PDOUT:  dout_level = data_out_sources[2];
			GSPR_FN_PDOUT2: dout_level = data_out_sources[3];
			GSPR_FN_SDOUT:  dout_level = data_out_sources[4];
			GSPR_FN_SDOUT2: dout_level = data_out_sources[5];
			GSPR_FN_SBCLK:  dout_level = data_out_sources[6];
			GSPR_FN_GENERAL_CLOCK_OUTPUT: dout_level = data_out_sources[7];
			// muxed: either data output, whichever slot drives
			GSPR_FN_MUXED:  dout_level =
				data_out_sources[2] | data_out_sources[4];
			GSPR_FN_DAISY:  dout_level = primary_din_pin;
			GSPR_FN_LOOP:   dout_level = primary_din_pin;
			// disabled, input, undefined and reserved codes float
			GSPR_FN_DISABLED, GSPR_FN_INPUT, GSPR_FN_UNDEF,
			GSPR_FN_RSVD:   dout_active = 1'b0;
		endcase
	end

	gspr_pad_drive u_dout_pad (
		.drive    (st.doutcfg[2:0]),
		.level    (dout_level),
		.active   (dout_active),
		.pad_out  (data_out_pin_out),
		.pad_oe   (data_out_pin_oe),
		.pad_weak (data_out_pin_weak)
	);

	assign data_out_function    = st.doutcfg[7:4];
	assign data_out_input_level = (fn == GSPR_FN_INPUT) & data_out_pin_in;
endmodule

/* testbench/gspr_props.sv */
// gspr_props: port assertions for the pin routing block
// assumes it is bound into gspr_top, all logic on mclk
`timescale 1ns/1ns
module gspr_props (
	input wire logic       mclk,
	input wire logic       rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic       reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic [3:0] outonly_pin_function,
	input wire logic       bidir_pin_out,
	input wire logic       outonly_pin_gpo_out,
	input wire logic       outonly_pin_gpo_active,
	input wire logic       primary_bclk_pin,
	input wire logic       primary_fsync_pin,
	input wire logic       secondary_bclk,
	input wire logic       secondary_fsync,
	input wire logic       primary_bclk,
	input wire logic       primary_fsync,
	input wire logic       control_clock_active,
	input wire logic [3:0] data_out_function
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	logic w_val, w_rte, w_cfg;
	assign w_val = reg_wr && reg_addr == 8'h0e;
	assign w_rte = reg_wr && reg_addr == 8'h0f;
	assign w_cfg = reg_wr && reg_addr == 8'h10;
	bidir_value_a: assert property (w_val |=>
		bidir_pin_out == $past(reg_wdata[7])) else $error("bidir level wrong");
	outonly_value_a: assert property (w_val |=>
		outonly_pin_gpo_out == $past(reg_wdata[5])) else $error("outonly wrong");
	outonly_gate_a: assert property (
		outonly_pin_gpo_active == (outonly_pin_function == 4'h2))
		else $error("outonly active flag wrong");
	cclk_active_a: assert property (w_rte |=>
		control_clock_active == ($past(reg_wdata[6:5]) != 2'h0))
		else $error("control clock enable wrong");
	bclk_route_a: assert property (w_rte |=> primary_bclk ==
		($past(reg_wdata[1]) ? secondary_bclk : primary_bclk_pin))
		else $error("bit clock route wrong");
	fsync_route_a: assert property (w_rte |=> primary_fsync ==
		($past(reg_wdata[0]) ? secondary_fsync : primary_fsync_pin))
		else $error("frame sync route wrong");
	dout_func_a: assert property (w_cfg |=>
		data_out_function == $past(reg_wdata[7:4])) else $error("function bad");
	unmapped_read_a: assert property (
		!(reg_addr inside {8'h0e, 8'h0f, 8'h10}) |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	reset_value_a: assert property (
		$rose(rst_n) && !reg_wr && reg_addr == 8'h10 |=> reg_rdata == 8'h52)
		else $error("config reset value wrong");
	cover property (w_rte && reg_wdata[1]);
	cover property (w_cfg && reg_wdata[7:4] == 4'hc);
	cover property (outonly_pin_gpo_active && outonly_pin_gpo_out);
endmodule
bind gspr_top gspr_props i_props (.*);

/* testbench/testbench.sv */
// testbench: register-driven checks of the pin routing block
// assumes gspr_top with a synchronous byte register port
`timescale 1ns/1ns
module testbench;
	import gspr_pkg::*;
	logic mclk, rst_n, reg_wr, bidir_is_output, bidir_is_input, bidir_pin_in;
	logic input_pin_one_enabled, input_pin_two_enabled, input_pin_one;
	logic input_pin_two, primary_din_pin, primary_bclk_pin, primary_fsync_pin;
	logic secondary_bclk, secondary_fsync, data_out_pin_in, bidir_pin_out;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, data_out_sources;
	logic [3:0] outonly_pin_function, data_out_function;
	logic bidir_pin_oe, outonly_pin_gpo_out, outonly_pin_gpo_active;
	logic control_clock, control_clock_active, primary_second_input;
	logic primary_second_input_en, primary_bclk, primary_fsync;
	logic data_out_pin_out, data_out_pin_oe, data_out_pin_weak;
	logic data_out_input_level, e;
	logic [5:0] s;
	int fail_count = 0, n_tests = 0, k, p, d, v;
	gspr_top i_dut (.*);
	always #10 mclk = ~mclk;
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task tick;
		@(posedge mclk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] dt);
		reg_addr = a;
		reg_wdata = dt;
		reg_wr = 1;
		tick;
	endtask
	// write strobe stays up until a read or the next write moves on
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		reg_wr = 0;
		reg_addr = a;
		tick;
		chk(reg_rdata, exp);
	endtask
	// expected data-out level; codes 13 and 14 both forward the data input
	function automatic logic lvl(int f, logic vb);
		if (f == 2) return vb;
		if (f >= 3 && f <= 10) return data_out_sources[f-3];
		if (f == 12) return data_out_sources[2] | data_out_sources[4];
		return primary_din_pin;
	endfunction
	task stop_test;
		if (fail_count == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		{reg_wr, bidir_is_output, bidir_is_input, input_pin_one_enabled,
			input_pin_two_enabled, bidir_pin_in, input_pin_one, input_pin_two,
			primary_din_pin, primary_bclk_pin, secondary_fsync,
			data_out_pin_in, rst_n, mclk} = '0;
		{primary_fsync_pin, secondary_bclk} = 2'b11;
		{reg_addr, reg_wdata, data_out_sources, outonly_pin_function} =
			{8'h10, 20'h0_0000};
		repeat (8) @(posedge mclk);
		#1 rst_n = 1;
		rd(8'h0e, 8'h00);
		rd(8'h0f, 8'h00);
		rd(8'h10, 8'h52);
		wr(8'h11, 8'hff);
		rd(8'h11, 8'h00);
		{bidir_is_input, input_pin_one_enabled, input_pin_two_enabled} = 3'b111;
		{bidir_is_output, outonly_pin_function} = {1'b1, 4'h2};
		for (p = 0; p < 2; p++) begin
			{input_pin_one, input_pin_two, bidir_pin_in} = p ? 3'b101 : 3'b010;
			// reserved bits written only with zeros
			wr(8'h0e, p ? 8'ha0 : 8'h00);
			chk(bidir_pin_out, p);
			chk(bidir_pin_oe, 1);
			chk(outonly_pin_gpo_out, p);
			rd(8'h0e, p ? 8'haa : 8'h04);
		end
		outonly_pin_function = 4'h5;
		{bidir_is_output, bidir_is_input} = 2'b00;
		{input_pin_one_enabled, input_pin_two_enabled} = 2'b00;
		{input_pin_one, input_pin_two, bidir_pin_in} = 3'b010;
		tick;
		chk(outonly_pin_gpo_active, 0);
		chk(outonly_pin_gpo_out, 1);
		chk(bidir_pin_oe, 0);
		chk(bidir_pin_out, 1);
		// monitors keep their last level once the pins stop being inputs
		rd(8'h0e, 8'haa);
		for (k = 0; k < 8; k++) begin
			for (p = 0; p < 2; p++) begin
				s = p ? 6'b101010 : 6'b010100;
				{primary_din_pin, data_out_pin_in, input_pin_one, input_pin_two,
					bidir_pin_in} = s[5:1];
				wr(8'h0f, {1'b0, k[1:0], k[2:0], p[0], p[0]});
				chk(primary_bclk, p);
				chk(primary_fsync, !p);
				chk(control_clock_active, k[1:0] != 0);
				if (k[1:0] != 0) chk(control_clock, s[k[1:0]]);
				e = k inside {[1:5]};
				chk(primary_second_input_en, e);
				if (e) chk(primary_second_input, s[k]);
			end
		end
		rd(8'h0f, 8'h7f);
		for (k = 0; k < 16; k++) begin
			for (p = 0; p < 2; p++) begin
				{data_out_sources, primary_din_pin} = {p ? 8'h55 : 8'haa, p[0]};
				data_out_pin_in = !p;
				wr(8'h10, {k[3:0], p[0], 3'h1});
				chk(data_out_function, k[3:0]);
				if (k < 2 || k == 11 || k == 15)
					chk(data_out_pin_oe, 0);
				if (k == 1) chk(data_out_input_level, !p);
				if (k >= 2 && k != 11 && k != 15) begin
					chk(data_out_pin_oe, 1);
					chk(data_out_pin_out, lvl(k, p[0]));
				end
			end
		end
		for (d = 0; d < 8; d++) begin
			for (v = 0; v < 2; v++) begin
				wr(8'h10, {4'h2, v[0], d[2:0]});
				e = d == 1 || (d inside {2, 3} && !v) || (d inside {4, 5} && v);
				chk(data_out_pin_oe, e);
				if (e) chk(data_out_pin_out, v);
				chk(data_out_pin_weak, (d == 2 && v) || (d == 4 && !v));
			end
		end
		// second reset mid-run must restore the config defaults
		rst_n = 0;
		tick;
		rst_n = 1;
		rd(8'h10, 8'h52);
		rd(8'h0f, 8'h00);
		stop_test;
	end
	initial begin
		#20000;
		fail_count++;
		stop_test;
	end
endmodule
